// >>> utx_pkg.sv
// Shared constants and carrier types for the transmit rate and special character block
package utx_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_SPECIAL_CHAR_ONE = 10'h009;
  localparam logic [9:0] IDX_SPECIAL_CHAR_TWO = 10'h00A;
  localparam logic [9:0] IDX_SPECIAL_CHAR_THREE = 10'h00B;
  localparam logic [9:0] IDX_SPECIAL_CHAR_FOUR = 10'h00C;
  localparam logic [9:0] IDX_TX_RATE_DIVISOR_HIGH = 10'h039;
  localparam logic [9:0] IDX_TX_RATE_DIVISOR_LOW = 10'h03A;
  localparam logic [9:0] IDX_CONTROL = 10'h040;
  localparam logic [9:0] IDX_COMMAND = 10'h041;
  localparam logic [9:0] IDX_TX_DATA = 10'h042;
  localparam logic [9:0] IDX_STATUS = 10'h043;

  localparam logic [7:0] CHAR_RESET = 8'h00;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;
  localparam logic [1:0] CONTROL_RESET = 2'h0;

  // Control fields
  localparam int CTL_TWO_CHAR_TX = 0;
  localparam int CTL_DOUBLE_CMP = 1;
  // Command fields
  localparam int CMD_SEND_ONE = 0;
  localparam int CMD_SEND_TWO = 1;
  // Status fields
  localparam int STS_TX_BUSY = 0;
  localparam int STS_SEQ_PENDING = 1;
  localparam int STS_FIFO_NONEMPTY = 2;
  localparam int STS_PAIR_PENDING = 3;

  // Serial frame: one start, eight data, one stop, sixteen ticks per bit
  localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
  localparam logic [3:0] TICKS_LAST = 4'hF;

  // Receive match codes
  localparam logic [2:0] MATCH_NONE = 3'h0;
  localparam logic [2:0] MATCH_ONE = 3'h1;
  localparam logic [2:0] MATCH_TWO = 3'h2;
  localparam logic [2:0] MATCH_THREE = 3'h3;
  localparam logic [2:0] MATCH_FOUR = 3'h4;
  localparam logic [2:0] MATCH_ON_PAIR = 3'h5;
  localparam logic [2:0] MATCH_OFF_PAIR = 3'h6;

  typedef struct packed {
    logic [7:0] chr;
    logic [2:0] match;
  } utx_rx_status_s;
endpackage : utx_pkg

// >>> utx_top.sv
// Transmit bit-rate generator, special character send and compare, with APB registers
`timescale 1ns/1ps
`default_nettype none

module utx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("utx_fifo depth must be a power of two of at least two");
  end

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : utx_fifo

module utx_top #(
  parameter int FIFO_DEPTH = 16,
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  output logic rx_status_valid,
  output utx_pkg::utx_rx_status_s rx_status,
  output logic tx_tick,
  output logic txd
);
  if (ADDR_W < 12 || ADDR_W > 32)
  begin : g_bad_addr
    $error("utx_top address width must hold the register map");
  end

  logic [7:0] sc_q [4];
  logic [7:0] div_hi_q;
  logic [7:0] div_lo_q;
  logic [1:0] ctl_q;
  logic [15:0] cnt_q;
  logic [15:0] preload;
  logic [1:0] pend_cnt_q;
  logic [7:0] pend_q [2];
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic busy_q;
  logic [9:0] sh_q;
  logic [3:0] bit_q;
  logic [3:0] sub_q;
  logic [2:0] pair_q;
  logic [2:0] pair_d;
  logic [2:0] code;
  logic [9:0] idx;
  logic mapped;
  logic writable;
  logic access;
  logic done;
  logic [31:0] rdata;

  // Bus decode; command and data writes wait while a sequence is pending
  assign idx = paddr[11:2];
  assign access = psel && penable && !pready;
  assign done = psel && penable && pready && !pslverr;
  always_comb
  begin
    // Shift rather than slice, so the minimum address width still elaborates
    mapped = (paddr[1:0] == 2'h0) && ((paddr >> 12) == '0);
    unique case (idx)
      utx_pkg::IDX_SPECIAL_CHAR_ONE, utx_pkg::IDX_SPECIAL_CHAR_TWO,
      utx_pkg::IDX_SPECIAL_CHAR_THREE, utx_pkg::IDX_SPECIAL_CHAR_FOUR,
      utx_pkg::IDX_TX_RATE_DIVISOR_HIGH, utx_pkg::IDX_TX_RATE_DIVISOR_LOW,
      utx_pkg::IDX_CONTROL, utx_pkg::IDX_COMMAND, utx_pkg::IDX_TX_DATA,
      utx_pkg::IDX_STATUS: ;
      default: mapped = 1'b0;
    endcase
  end
  assign writable = !(pwrite && (idx == utx_pkg::IDX_COMMAND || idx == utx_pkg::IDX_TX_DATA))
                    || (pend_cnt_q == 2'h0);

  always_comb
  begin
    rdata = 32'h0000_0000;
    unique case (idx)
      utx_pkg::IDX_SPECIAL_CHAR_ONE: rdata[7:0] = sc_q[0];
      utx_pkg::IDX_SPECIAL_CHAR_TWO: rdata[7:0] = sc_q[1];
      utx_pkg::IDX_SPECIAL_CHAR_THREE: rdata[7:0] = sc_q[2];
      utx_pkg::IDX_SPECIAL_CHAR_FOUR: rdata[7:0] = sc_q[3];
      utx_pkg::IDX_TX_RATE_DIVISOR_HIGH: rdata[7:0] = div_hi_q;
      utx_pkg::IDX_TX_RATE_DIVISOR_LOW: rdata[7:0] = div_lo_q;
      utx_pkg::IDX_CONTROL: rdata[1:0] = ctl_q;
      utx_pkg::IDX_STATUS:
      begin
        rdata[utx_pkg::STS_TX_BUSY] = busy_q;
        rdata[utx_pkg::STS_SEQ_PENDING] = (pend_cnt_q != 2'h0);
        rdata[utx_pkg::STS_FIFO_NONEMPTY] = fifo_out_valid;
        rdata[utx_pkg::STS_PAIR_PENDING] = (pair_q != utx_pkg::MATCH_NONE);
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (access && (writable || !mapped))
    begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= (mapped && !pwrite) ? rdata : 32'h0000_0000;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_hi_q <= utx_pkg::DIVISOR_RESET;
      div_lo_q <= utx_pkg::DIVISOR_RESET;
      ctl_q <= utx_pkg::CONTROL_RESET;
      for (int i = 0; i < 4; i++)
      begin
        sc_q[i] <= utx_pkg::CHAR_RESET;
      end
    end
    else if (done && pwrite)
    begin
      unique case (idx)
        utx_pkg::IDX_SPECIAL_CHAR_ONE: sc_q[0] <= pwdata[7:0];
        utx_pkg::IDX_SPECIAL_CHAR_TWO: sc_q[1] <= pwdata[7:0];
        utx_pkg::IDX_SPECIAL_CHAR_THREE: sc_q[2] <= pwdata[7:0];
        utx_pkg::IDX_SPECIAL_CHAR_FOUR: sc_q[3] <= pwdata[7:0];
        utx_pkg::IDX_TX_RATE_DIVISOR_HIGH: div_hi_q <= pwdata[7:0];
        utx_pkg::IDX_TX_RATE_DIVISOR_LOW: div_lo_q <= pwdata[7:0];
        utx_pkg::IDX_CONTROL: ctl_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  assign preload = {div_hi_q, div_lo_q};

  // Reload after counting preload
  // A zero preload stops the clock rather than ticking every cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n || preload == 16'h0000)
    begin
      cnt_q <= 16'h0000;
      tx_tick <= 1'b0;
    end
    else if (cnt_q + 16'h0001 >= preload)
    begin
      cnt_q <= 16'h0000;
      tx_tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 16'h0001;
      tx_tick <= 1'b0;
    end
  end

  // Command sequencer feeds the FIFO one character at a time
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pend_cnt_q <= 2'h0;
      pend_q[0] <= 8'h00;
      pend_q[1] <= 8'h00;
    end
    else if (done && pwrite && idx == utx_pkg::IDX_COMMAND)
    begin
      if (pwdata[utx_pkg::CMD_SEND_ONE])
      begin
        pend_q[0] <= sc_q[0];
        pend_q[1] <= sc_q[2];
        pend_cnt_q <= ctl_q[utx_pkg::CTL_TWO_CHAR_TX] ? 2'h2 : 2'h1;
      end
      else if (pwdata[utx_pkg::CMD_SEND_TWO])
      begin
        pend_q[0] <= sc_q[1];
        pend_q[1] <= sc_q[3];
        pend_cnt_q <= ctl_q[utx_pkg::CTL_TWO_CHAR_TX] ? 2'h2 : 2'h1;
      end
    end
    else if (done && pwrite && idx == utx_pkg::IDX_TX_DATA)
    begin
      pend_q[0] <= pwdata[7:0];
      pend_cnt_q <= 2'h1;
    end
    else if (pend_cnt_q != 2'h0 && fifo_in_ready)
    begin
      pend_q[0] <= pend_q[1];
      pend_cnt_q <= pend_cnt_q - 2'h1;
    end
  end

  utx_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(pend_cnt_q != 2'h0),
    .in_ready(fifo_in_ready),
    .in_data(pend_q[0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Serialiser drains the FIFO only when idle, so a stopped clock fills it
  assign fifo_out_ready = !busy_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy_q <= 1'b0;
      txd <= 1'b1;
      sh_q <= 10'h3FF;
      bit_q <= 4'h0;
      sub_q <= 4'h0;
    end
    else if (!busy_q)
    begin
      if (fifo_out_valid)
      begin
        busy_q <= 1'b1;
        sh_q <= {1'b1, fifo_out_data, 1'b0};
        txd <= 1'b0;
        bit_q <= 4'h0;
        sub_q <= 4'h0;
      end
    end
    else if (tx_tick)
    begin
      sub_q <= sub_q + 4'h1;
      if (sub_q == utx_pkg::TICKS_LAST)
      begin
        if (bit_q == utx_pkg::FRAME_LAST_BIT)
        begin
          busy_q <= 1'b0;
          txd <= 1'b1;
        end
        else
        begin
          sh_q <= {1'b1, sh_q[9:1]};
          txd <= sh_q[1];
          bit_q <= bit_q + 4'h1;
        end
      end
    end
  end

  always_comb
  begin
    pair_d = utx_pkg::MATCH_NONE;
    if (rx_char == sc_q[0])
    begin
      code = utx_pkg::MATCH_ONE;
    end
    else if (rx_char == sc_q[1])
    begin
      code = utx_pkg::MATCH_TWO;
    end
    else if (rx_char == sc_q[2])
    begin
      code = utx_pkg::MATCH_THREE;
    end
    else if (rx_char == sc_q[3])
    begin
      code = utx_pkg::MATCH_FOUR;
    end
    else
    begin
      code = utx_pkg::MATCH_NONE;
    end
    if (ctl_q[utx_pkg::CTL_DOUBLE_CMP])
    begin
      if (pair_q == utx_pkg::MATCH_ONE && rx_char == sc_q[2])
      begin
        code = utx_pkg::MATCH_ON_PAIR;
      end
      else if (pair_q == utx_pkg::MATCH_TWO && rx_char == sc_q[3])
      begin
        code = utx_pkg::MATCH_OFF_PAIR;
      end
      else
      begin
        pair_d = (rx_char == sc_q[0]) ? utx_pkg::MATCH_ONE :
                 (rx_char == sc_q[1]) ? utx_pkg::MATCH_TWO : utx_pkg::MATCH_NONE;
        code = utx_pkg::MATCH_NONE;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pair_q <= utx_pkg::MATCH_NONE;
      rx_status_valid <= 1'b0;
      rx_status <= '0;
    end
    else
    begin
      rx_status_valid <= rx_char_valid;
      if (rx_char_valid)
      begin
        pair_q <= pair_d;
        rx_status.chr <= rx_char;
        rx_status.match <= code;
      end
    end
  end

  sequence s_cmd_one;
    done && pwrite && idx == utx_pkg::IDX_COMMAND && pwdata[utx_pkg::CMD_SEND_ONE];
  endsequence
  sequence s_cmd_two;
    done && pwrite && idx == utx_pkg::IDX_COMMAND && !pwdata[utx_pkg::CMD_SEND_ONE]
      && pwdata[utx_pkg::CMD_SEND_TWO];
  endsequence

  // Preload assembled from both bytes
  // A lowered preload may leave the count above it for the one cycle before reload
  preload_bytes_a: assert property (@(posedge clk) disable iff (!rst_n)
    preload == {div_hi_q, div_lo_q} && (cnt_q < preload || preload == 16'h0000 || $changed(preload)))
    else $error("preload counter out of range");
  tick_period_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_tick && preload == 16'h0005) |=> ((!tx_tick)[*4] ##1 tx_tick) or (##[0:4] (preload != 16'h0005)))
    else $error("tick spacing wrong");
  tick_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
    tx_tick |-> cnt_q == 16'h0000 && $past(preload) != 16'h0000 && $past(cnt_q) + 16'h0001 >= $past(preload))
    else $error("counter not reloaded");
  reset_clear_a: assert property (@(posedge clk)
    !rst_n |=> div_hi_q == 8'h00 && div_lo_q == 8'h00 && !tx_tick) else $error("reset left divisor");
  send_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_cmd_one |=> pend_q[0] == $past(sc_q[0]) && pend_cnt_q != 2'h0) else $error("send one lost");
  send_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_cmd_two ##0 ctl_q[utx_pkg::CTL_TWO_CHAR_TX]) |=> pend_cnt_q == 2'h2 && pend_q[0] == $past(sc_q[1])
      && pend_q[1] == $past(sc_q[3])) else $error("xoff pair wrong");
  send_two_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_cmd_two ##0 !ctl_q[utx_pkg::CTL_TWO_CHAR_TX]) |=> pend_cnt_q == 2'h1
      && pend_q[0] == $past(sc_q[1])) else $error("send two wrong");
  rx_match_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_char_valid && !ctl_q[utx_pkg::CTL_DOUBLE_CMP] && rx_char == sc_q[0]) |=>
      rx_status_valid && rx_status.match == utx_pkg::MATCH_ONE) else $error("match not recorded");
  rx_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_char_valid && ctl_q[utx_pkg::CTL_DOUBLE_CMP] && pair_q == utx_pkg::MATCH_NONE) |=>
      rx_status.match == utx_pkg::MATCH_NONE) else $error("pair reported early");
endmodule : utx_top

`default_nettype wire

// >>> utx_remote.sv
// Remote serial station model: decodes the line and sends characters to the receive compare inputs
`timescale 1ns/1ps
`default_nettype none

module utx_remote (
  input wire logic clk,
  input wire logic tx_tick,
  input wire logic txd,
  output logic rx_char_valid,
  output logic [7:0] rx_char
);
  logic [7:0] got[$];
  logic [7:0] sr;
  int cnt = -1;

  initial
  begin
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    sr = 8'h00;
  end

  // Sample mid-bit on the 16x tick, LSB first; a bad stop bit drops the frame
  always @(posedge clk)
  begin
    if (tx_tick === 1'b1)
    begin
      if (cnt < 0)
      begin
        if (txd === 1'b0)
          cnt = 0;
      end
      else
      begin
        cnt = cnt + 1;
        if (cnt % 16 == 8 && cnt > 8 && cnt < 152)
          sr[cnt / 16 - 1] = txd;
        if (cnt == 152)
        begin
          if (txd === 1'b1)
            got.push_back(sr);
          cnt = -1;
        end
      end
    end
  end

  // Line shows the inverse once the character is no longer valid
  task send_char(input logic [7:0] c);
    @(posedge clk);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    @(posedge clk);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
  endtask : send_char
endmodule : utx_remote

`default_nettype wire

// >>> uart_tx_baud_and_special_chars_bench.sv
// Testbench: registers, rate ticks, special character send and compare
`timescale 1ns/1ps
`default_nettype none

module uart_tx_baud_and_special_chars_bench;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic rx_char_valid, rx_status_valid, tx_tick, txd, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0] rx_char;
  utx_pkg::utx_rx_status_s rx_status;
  int errors = 0;
  int n_compared = 0;

  utx_top dut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .rx_status_valid(rx_status_valid), .rx_status(rx_status), .tx_tick(tx_tick), .txd(txd));
  utx_remote remote (.clk(clk), .tx_tick(tx_tick), .txd(txd), .rx_char_valid(rx_char_valid), .rx_char(rx_char));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task stop_test;
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk

  // Request held until pready seen high; a stalled command may take several frames
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Values read right after the edge are the ones the edge sampled
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 3000);
    if (n >= 3000)
      chk(32'h0, 32'h1, "apb hang");
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [9:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask : wr

  task rd(input logic [9:0] i, input logic [31:0] e);
    apb(1'b0, {i, 2'b00}, 32'h0);
    chk(rdat, e, "read");
  endtask : rd

  task t_reset_vals;
    chk({31'h0, txd}, 32'h1, "idle line");
    rd(utx_pkg::IDX_SPECIAL_CHAR_ONE, 32'h0);
    rd(utx_pkg::IDX_SPECIAL_CHAR_TWO, 32'h0);
    rd(utx_pkg::IDX_TX_RATE_DIVISOR_HIGH, 32'h0);
    rd(utx_pkg::IDX_TX_RATE_DIVISOR_LOW, 32'h0);
  endtask : t_reset_vals

  task t_reg_access;
    wr(utx_pkg::IDX_SPECIAL_CHAR_ONE, 32'hA5);
    wr(utx_pkg::IDX_SPECIAL_CHAR_TWO, 32'h3C);
    wr(utx_pkg::IDX_TX_RATE_DIVISOR_HIGH, 32'h12);
    wr(utx_pkg::IDX_TX_RATE_DIVISOR_LOW, 32'h34);
    rd(utx_pkg::IDX_SPECIAL_CHAR_ONE, 32'hA5);
    rd(utx_pkg::IDX_SPECIAL_CHAR_TWO, 32'h3C);
    rd(utx_pkg::IDX_TX_RATE_DIVISOR_HIGH, 32'h12);
    rd(utx_pkg::IDX_TX_RATE_DIVISOR_LOW, 32'h34);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped error");
    apb(1'b1, {utx_pkg::IDX_SPECIAL_CHAR_ONE, 2'b01}, 32'h77);
    chk({31'h0, rerr}, 32'h1, "misaligned error");
    rd(utx_pkg::IDX_SPECIAL_CHAR_ONE, 32'hA5);
  endtask : t_reg_access

  // Later passes skip the partial period left by a divisor change
  task tick_period(input logic [15:0] p);
    int n;
    wr(utx_pkg::IDX_TX_RATE_DIVISOR_HIGH, {24'h0, p[15:8]});
    wr(utx_pkg::IDX_TX_RATE_DIVISOR_LOW, {24'h0, p[7:0]});
    n = 0;
    repeat (3)
    begin
      @(negedge clk);
      n = 1;
      while (tx_tick !== 1'b1 && n < 2000)
      begin
        @(negedge clk);
        n++;
      end
    end
    chk(n, {16'h0, p}, "tick period");
  endtask : tick_period

  task expect_tx(input logic [7:0] c);
    int n;
    n = 0;
    while (remote.got.size() == 0 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (remote.got.size() == 0)
      chk(32'h0, {24'h0, c}, "no character");
    else
      chk({24'h0, remote.got.pop_front()}, {24'h0, c}, "sent character");
  endtask : expect_tx

  task t_send;
    wr(utx_pkg::IDX_SPECIAL_CHAR_ONE, 32'h11);
    wr(utx_pkg::IDX_SPECIAL_CHAR_TWO, 32'h22);
    wr(utx_pkg::IDX_SPECIAL_CHAR_THREE, 32'h33);
    wr(utx_pkg::IDX_SPECIAL_CHAR_FOUR, 32'h44);
    tick_period(16'h0004);
    wr(utx_pkg::IDX_COMMAND, 32'h1 << utx_pkg::CMD_SEND_ONE);
    expect_tx(8'h11);
    wr(utx_pkg::IDX_COMMAND, 32'h1 << utx_pkg::CMD_SEND_TWO);
    expect_tx(8'h22);
    wr(utx_pkg::IDX_CONTROL, 32'h1 << utx_pkg::CTL_TWO_CHAR_TX);
    wr(utx_pkg::IDX_COMMAND, 32'h1 << utx_pkg::CMD_SEND_ONE);
    wr(utx_pkg::IDX_COMMAND, 32'h1 << utx_pkg::CMD_SEND_TWO);
    expect_tx(8'h11);
    expect_tx(8'h33);
    expect_tx(8'h22);
    expect_tx(8'h44);
  endtask : t_send

  task rx_expect(input logic [7:0] c, input logic [2:0] m);
    int n;
    remote.send_char(c);
    n = 0;
    while (rx_status_valid !== 1'b1 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    chk({21'h0, rx_status}, {21'h0, c, m}, "rx status");
  endtask : rx_expect

  task t_rx;
    wr(utx_pkg::IDX_CONTROL, 32'h0);
    rx_expect(8'h11, utx_pkg::MATCH_ONE);
    rx_expect(8'h22, utx_pkg::MATCH_TWO);
    rx_expect(8'h33, utx_pkg::MATCH_THREE);
    rx_expect(8'h44, utx_pkg::MATCH_FOUR);
    rx_expect(8'h5A, utx_pkg::MATCH_NONE);
    wr(utx_pkg::IDX_CONTROL, 32'h1 << utx_pkg::CTL_DOUBLE_CMP);
    rx_expect(8'h11, utx_pkg::MATCH_NONE);
    rx_expect(8'h33, utx_pkg::MATCH_ON_PAIR);
    rx_expect(8'h22, utx_pkg::MATCH_NONE);
    rx_expect(8'h44, utx_pkg::MATCH_OFF_PAIR);
  endtask : t_rx

  // Zero preload stalls the line after the first character, so the queue holds the other 15 before draining
  task t_fifo;
    int i;
    wr(utx_pkg::IDX_CONTROL, 32'h0);
    wr(utx_pkg::IDX_TX_RATE_DIVISOR_LOW, 32'h0);
    for (i = 0; i < 16; i++)
      wr(utx_pkg::IDX_TX_DATA, 32'h80 + i);
    rd(utx_pkg::IDX_STATUS, 32'h5);
    wr(utx_pkg::IDX_TX_RATE_DIVISOR_LOW, 32'h4);
    for (i = 0; i < 16; i++)
      expect_tx(8'h80 + i[7:0]);
    repeat (700) @(negedge clk);
    rd(utx_pkg::IDX_STATUS, 32'h0);
    chk(remote.got.size(), 32'h0, "extra characters");
  endtask : t_fifo

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_vals();
    t_reg_access();
    tick_period(16'h0005);
    tick_period(16'h0102);
    t_send();
    t_rx();
    t_fifo();
    stop_test();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule : uart_tx_baud_and_special_chars_bench

`default_nettype wire
